// File: rtl/caf_pkg.sv
// Package for the CAN acceptance filter control block (filters 20 to 31).
// Assumes one 250 MHz clock and an APB3 slave with 32-bit data.
package caf_pkg;
   localparam int CAF_FIRST_FILTER = 20;
   localparam int CAF_NUM_FILTERS = 12;
   localparam int CAF_PER_GROUP = 4;
   localparam int CAF_NUM_GROUPS = 3;
   localparam int CAF_CLK_MHZ = 250;

   // Byte addresses on the register bus.
   localparam logic [7:0] CAF_CTRL_OFS = 8'h00;
   localparam logic [7:0] CAF_IDENT_OFS = 8'h10;
   localparam logic [7:0] CAF_STATUS_OFS = 8'h40;

   // Layout of one filter control byte.
   localparam int CAF_EN_BIT = 7;
   localparam int CAF_MSEL_LO = 5;
   localparam int CAF_FSEL_LO = 0;
   localparam logic [1:0] CAF_MASK0 = 2'h0;
   localparam logic [1:0] CAF_MASK1 = 2'h1;
   localparam logic [1:0] CAF_MASK2 = 2'h2;
   localparam logic [1:0] CAF_MASK3 = 2'h3;

   // Layout of an identifier word: standard part 31:21, format flag 19, extended part 17:0.
   localparam logic [31:0] CAF_SID_BITS = 32'hFFE0_0000;
   localparam logic [31:0] CAF_EXT_BIT = 32'h0008_0000;
   localparam logic [31:0] CAF_IDENT_IMPL = 32'hFFEB_FFFF;
   localparam int CAF_EXT_POS = 19;

   // Status register fields.
   localparam int CAF_ST_FIFO_LO = 0;
   localparam int CAF_ST_FILT_LO = 8;
   localparam int CAF_ST_VALID = 16;

   localparam logic [7:0] CAF_CTRL_RESET = 8'h00;
   localparam logic [31:0] CAF_IDENT_RESET = 32'h0000_0000;
endpackage

// File: rtl/caf_filter_slot.sv
// One acceptance filter: its control byte, its identifier value and its comparison.
// Assumes write strobes come from the bus decoder on the same clock.
`timescale 1ns/1ns
`default_nettype none
module caf_filter_slot
   import caf_pkg::*;
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic ctrl_we,
   input wire logic [7:0] ctrl_wdata,
   input wire logic ident_we,
   input wire logic [31:0] ident_wdata,
   input wire logic [31:0] mask_0,
   input wire logic [31:0] mask_1,
   input wire logic [31:0] mask_2,
   input wire logic [31:0] mask_3,
   input wire logic [31:0] rx_ident,
   output logic [7:0] ctrl,
   output logic [31:0] ident,
   output logic hit
);
   logic filter_on;
   logic [1:0] mask_choice;
   logic [4:0] fifo_target;
   logic [31:0] sel_mask;
   logic [31:0] eff_mask;
   logic [31:0] diff;

   assign ctrl = {filter_on, mask_choice, fifo_target};

   ////////////////////////////////////////////////////////////////////////////////
   // Fields only move while the filter is off, so a live comparison never sees a
   // half-changed setup. The enable bit itself is always writable.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         filter_on <= CAF_CTRL_RESET[CAF_EN_BIT];
         mask_choice <= CAF_CTRL_RESET[CAF_MSEL_LO +: 2];
         fifo_target <= CAF_CTRL_RESET[CAF_FSEL_LO +: 5];
         ident <= CAF_IDENT_RESET;
      end else begin
         if (ctrl_we) begin
            filter_on <= ctrl_wdata[CAF_EN_BIT];
            if (!filter_on) begin
               mask_choice <= ctrl_wdata[CAF_MSEL_LO +: 2];
               fifo_target <= ctrl_wdata[CAF_FSEL_LO +: 5];
            end
         end
         if (ident_we && !filter_on) begin
            ident <= ident_wdata & CAF_IDENT_IMPL;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   assign sel_mask = (mask_choice == CAF_MASK3) ? mask_3 :
                     (mask_choice == CAF_MASK2) ? mask_2 :
                     (mask_choice == CAF_MASK1) ? mask_1 : mask_0;
   // A standard-format filter ignores the extended part; the format flag always counts.
   assign eff_mask = ((ident[CAF_EXT_POS] ? sel_mask : (sel_mask & CAF_SID_BITS))
                      | CAF_EXT_BIT) & CAF_IDENT_IMPL;
   assign diff = (rx_ident ^ ident) & eff_mask;
   assign hit = filter_on && (diff == 32'h0000_0000);

   ////////////////////////////////////////////////////////////////////////////////
   property p_lock;
      @(posedge mclk) disable iff (!reset_n)
      (ctrl_we && filter_on) |=> (ctrl[6:0] == $past(ctrl[6:0]));
   endproperty
   a_lock: assert property (p_lock) else $error("fields changed while enabled");

   property p_enable;
      @(posedge mclk) disable iff (!reset_n)
      ctrl_we |=> (filter_on == $past(ctrl_wdata[CAF_EN_BIT]));
   endproperty
   a_enable: assert property (p_enable) else $error("enable bit not written");

   property p_off_quiet;
      @(posedge mclk) disable iff (!reset_n)
      !filter_on |-> !hit;
   endproperty
   a_off_quiet: assert property (p_off_quiet) else $error("disabled filter hit");

   // A standard-part difference under mask 3 must always block the hit, whatever the format.
   property p_mask3;
      @(posedge mclk) disable iff (!reset_n)
      (mask_choice == CAF_MASK3 && ((rx_ident ^ ident) & mask_3 & CAF_SID_BITS) != 32'h0000_0000)
         |-> !hit;
   endproperty
   a_mask3: assert property (p_mask3) else $error("wrong mask chosen");

   property p_ident_lock;
      @(posedge mclk) disable iff (!reset_n)
      filter_on |=> $stable(ident);
   endproperty
   a_ident_lock: assert property (p_ident_lock) else $error("ident changed while on");

   property p_format;
      @(posedge mclk) disable iff (!reset_n)
      (rx_ident[CAF_EXT_POS] != ident[CAF_EXT_POS]) |-> !hit;
   endproperty
   a_format: assert property (p_format) else $error("format mismatch hit");
endmodule
`default_nettype wire

// File: rtl/caf_filter_ctrl.sv
// Contract
// - enable bit turns filter on or off
// - mask select picks mask zero to three
// - FIFO select names destination FIFO 0-31
// - byte: enable top, mask next, FIFO low
// - highest filter of group in bits 31:24
// - three registers, four filters each, ascending
// - all fields reset to zero
// - match unmasked identifier bits and format flag
//
// Top of the acceptance filter control block: APB3 slave, twelve filter slots and
// the routing of a received identifier to its FIFO.
// Assumes the receive path and the four masks are driven on mclk.
`timescale 1ns/1ns
`default_nettype none
module caf_filter_ctrl
   import caf_pkg::*;
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [31:0] mask_0,
   input wire logic [31:0] mask_1,
   input wire logic [31:0] mask_2,
   input wire logic [31:0] mask_3,
   input wire logic rx_valid,
   input wire logic [31:0] rx_ident,
   output logic rx_hit,
   output logic [4:0] rx_fifo,
   output logic [4:0] rx_filter,
   output logic [11:0] filter_on
);
   logic [7:0] ctrl [CAF_NUM_FILTERS];
   logic [31:0] ident [CAF_NUM_FILTERS];
   logic [CAF_NUM_FILTERS-1:0] hit;
   logic [CAF_NUM_GROUPS-1:0] ctrl_sel;
   logic [CAF_NUM_FILTERS-1:0] ident_sel;
   logic [31:0] group_word [CAF_NUM_GROUPS];
   wire logic access = psel && penable;
   wire logic wr = access && pwrite;
   wire logic status_sel = (paddr == CAF_STATUS_OFS);
   wire logic mapped = (|ctrl_sel) || (|ident_sel) || status_sel;
   logic [31:0] next_rdata;
   logic any_hit;
   logic [3:0] first_hit;
   logic last_valid;

   ////////////////////////////////////////////////////////////////////////////////
   // Register decode. Slot i sits in group i/4, byte lane i%4, so the
   // lowest filter of a group is in the low byte.
   genvar g;
   generate
      for (g = 0; g < CAF_NUM_GROUPS; g++) begin : grp
         assign ctrl_sel[g] = (paddr == CAF_CTRL_OFS + 8'(4 * g));
         assign group_word[g] = {ctrl[4*g+3], ctrl[4*g+2], ctrl[4*g+1], ctrl[4*g]};
      end
      for (g = 0; g < CAF_NUM_FILTERS; g++) begin : slot
         assign ident_sel[g] = (paddr == CAF_IDENT_OFS + 8'(4 * g));
         assign filter_on[g] = ctrl[g][CAF_EN_BIT];
         caf_filter_slot u_slot (
            .mclk(mclk),
            .reset_n(reset_n),
            .ctrl_we(wr && ctrl_sel[g / CAF_PER_GROUP]),
            .ctrl_wdata(pwdata[8 * (g % CAF_PER_GROUP) +: 8]),
            .ident_we(wr && ident_sel[g]),
            .ident_wdata(pwdata),
            .mask_0(mask_0),
            .mask_1(mask_1),
            .mask_2(mask_2),
            .mask_3(mask_3),
            .rx_ident(rx_ident),
            .ctrl(ctrl[g]),
            .ident(ident[g]),
            .hit(hit[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Read data is fetched in the setup cycle so the access phase needs no wait.
   always_comb begin
      next_rdata = 32'h0000_0000;
      for (int k = 0; k < CAF_NUM_GROUPS; k++) begin
         if (ctrl_sel[k]) begin
            next_rdata = group_word[k];
         end
      end
      for (int k = 0; k < CAF_NUM_FILTERS; k++) begin
         if (ident_sel[k]) begin
            next_rdata = ident[k];
         end
      end
      if (status_sel) begin
         next_rdata[CAF_ST_FIFO_LO +: 5] = rx_fifo;
         next_rdata[CAF_ST_FILT_LO +: 5] = rx_filter;
         next_rdata[CAF_ST_VALID] = last_valid;
      end
   end

   assign pready = 1'b1;
   assign pslverr = access && !mapped;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // The lowest-numbered matching filter wins when several accept one message.
   always_comb begin
      any_hit = 1'b0;
      first_hit = 4'h0;
      for (int k = CAF_NUM_FILTERS - 1; k >= 0; k--) begin
         if (hit[k]) begin
            any_hit = 1'b1;
            first_hit = 4'(k);
         end
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rx_hit <= 1'b0;
         rx_fifo <= 5'h00;
         rx_filter <= 5'h00;
         last_valid <= 1'b0;
      end else begin
         rx_hit <= rx_valid && any_hit;
         if (rx_valid && any_hit) begin
            rx_fifo <= ctrl[first_hit][CAF_FSEL_LO +: 5];
            rx_filter <= 5'(CAF_FIRST_FILTER) + 5'(first_hit);
            last_valid <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   property p_route;
      @(posedge mclk) disable iff (!reset_n)
      (rx_valid && any_hit) |=> (rx_hit && rx_fifo == $past(ctrl[first_hit][4:0]));
   endproperty
   a_route: assert property (p_route) else $error("message routed to wrong FIFO");

   property p_no_spurious;
      @(posedge mclk) disable iff (!reset_n)
      !(rx_valid && any_hit) |=> !rx_hit;
   endproperty
   a_no_spurious: assert property (p_no_spurious) else $error("hit without match");

   property p_group0_read;
      @(posedge mclk) disable iff (!reset_n)
      (psel && !penable && !pwrite && ctrl_sel[0] && !(wr)) |=>
         (prdata == {$past(ctrl[3]), $past(ctrl[2]), $past(ctrl[1]), $past(ctrl[0])});
   endproperty
   a_group0_read: assert property (p_group0_read) else $error("group read layout");

   property p_top_byte;
      @(posedge mclk) disable iff (!reset_n)
      (wr && ctrl_sel[1] && !filter_on[7]) |=> (ctrl[7][4:0] == $past(pwdata[28:24]));
   endproperty
   a_top_byte: assert property (p_top_byte) else $error("filter 27 field misplaced");

   property p_unmapped;
      @(posedge mclk) disable iff (!reset_n)
      (access && !mapped) |-> pslverr;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access not flagged");

   property p_group2_read;
      @(posedge mclk) disable iff (!reset_n)
      (psel && !penable && !pwrite && ctrl_sel[2]) |=>
         (prdata == {$past(ctrl[11]), $past(ctrl[10]), $past(ctrl[9]), $past(ctrl[8])});
   endproperty
   a_group2_read: assert property (p_group2_read) else $error("third group read layout");

   property p_enable_lane;
      @(posedge mclk) disable iff (!reset_n)
      (wr && ctrl_sel[0]) |=> (filter_on[0] == $past(pwdata[7]));
   endproperty
   a_enable_lane: assert property (p_enable_lane) else $error("enable bit lane");

   property p_mask_lane;
      @(posedge mclk) disable iff (!reset_n)
      (wr && ctrl_sel[2] && !filter_on[11]) |=> (ctrl[11][6:5] == $past(pwdata[30:29]));
   endproperty
   a_mask_lane: assert property (p_mask_lane) else $error("mask select lane");

   // The status word and the routing outputs must not drift between matches.
   property p_route_hold;
      @(posedge mclk) disable iff (!reset_n)
      !(rx_valid && any_hit) |=> ($stable(rx_fifo) && $stable(rx_filter));
   endproperty
   a_route_hold: assert property (p_route_hold) else $error("route moved without match");

   property p_lowest_number;
      @(posedge mclk) disable iff (!reset_n)
      (rx_valid && hit[0]) |=> (rx_filter == 5'(CAF_FIRST_FILTER));
   endproperty
   a_lowest_number: assert property (p_lowest_number) else $error("filter number wrong");

   property p_mapped_ok;
      @(posedge mclk) disable iff (!reset_n)
      (access && mapped) |-> !pslverr;
   endproperty
   a_mapped_ok: assert property (p_mapped_ok) else $error("mapped access flagged");

   property p_status_read;
      @(posedge mclk) disable iff (!reset_n)
      (psel && !penable && !pwrite && status_sel) |=> (prdata[4:0] == $past(rx_fifo));
   endproperty
   a_status_read: assert property (p_status_read) else $error("status FIFO field");
endmodule
`default_nettype wire

// File: verification/test_caf_filter_ctrl.sv
// Self-checking bench for the acceptance filter control block, filters 20 to 31.
// Assumes the design package is compiled first and the APB slave answers within a few cycles.
`timescale 1ns/1ns
`default_nettype none
module test_caf_filter_ctrl
   import caf_pkg::*;
;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic rx_valid = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] rx_ident = 32'h0000_0000;
   logic [31:0] mk [4] = '{32'h0, 32'h0, 32'h0, 32'h0};
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic rx_hit;
   logic [4:0] rx_fifo;
   logic [4:0] rx_filter;
   logic [11:0] filter_on;
   int fail_count = 0;
   int n_checks = 0;
   logic [31:0] q;
   logic e;

   always #2 mclk = ~mclk;

   caf_filter_ctrl dut_u (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .mask_0(mk[0]), .mask_1(mk[1]), .mask_2(mk[2]), .mask_3(mk[3]),
      .rx_valid(rx_valid), .rx_ident(rx_ident), .rx_hit(rx_hit), .rx_fifo(rx_fifo),
      .rx_filter(rx_filter), .filter_on(filter_on));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // The request is held until pready is seen high; a slow slave is served if it answers within 19 cycles, and pready first seen in cycle 20 fails.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge mclk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      if (i >= 20) begin
         fail_count++;
         stop_test();
      end else begin
         q = prdata;
         e = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   // Mask number open_m compares nothing, the other three compare the standard part.
   task automatic set_masks(input int open_m);
      mk <= '{(open_m == 0) ? 32'h0 : CAF_SID_BITS, (open_m == 1) ? 32'h0 : CAF_SID_BITS,
              (open_m == 2) ? 32'h0 : CAF_SID_BITS, (open_m == 3) ? 32'h0 : CAF_SID_BITS};
   endtask

   task automatic send(input logic [31:0] id, input logic h, input logic [4:0] f);
      @(posedge mclk);
      rx_valid <= 1'b1;
      rx_ident <= id;
      @(posedge mclk);
      rx_valid <= 1'b0;
      #1;
      chk(rx_hit, h);
      if (h) begin
         chk(rx_fifo, f);
         chk(rx_filter, 5'h1B);
      end
      @(posedge mclk);
      #1;
      chk(rx_hit, 1'b0);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      for (int g = 0; g < 3; g++) begin
         apb(1'b0, CAF_CTRL_OFS + 8'(4 * g), 32'h0);
         chk(q, 32'h0000_0000);
      end
      chk(filter_on, 12'h000);
   endtask

   task automatic t_layout();
      logic [31:0] pat [3] = '{32'h7F3E_5D1C, 32'h7F40_211E, 32'h1F60_4301};
      for (int g = 0; g < 3; g++) begin
         apb(1'b1, CAF_CTRL_OFS + 8'(4 * g), pat[g]);
         apb(1'b0, CAF_CTRL_OFS + 8'(4 * g), 32'h0);
         chk(q, pat[g]);
         chk(e, 1'b0);
         apb(1'b1, CAF_CTRL_OFS + 8'(4 * g), 32'h0);
      end
      apb(1'b1, 8'h04, 32'hFFC0_A19E);
      // The write lands on the edge the task returns at, so look just after it.
      #1;
      chk(filter_on, 12'h0F0);
      // Enabled filters must keep their fields; only the enable bit is taken.
      apb(1'b1, 8'h04, 32'h8080_8080);
      apb(1'b0, 8'h04, 32'h0);
      chk(q, 32'hFFC0_A19E);
      apb(1'b1, 8'h04, 32'h0000_0000);
      #1;
      chk(filter_on, 12'h000);
   endtask

   task automatic t_route();
      logic [4:0] fifo [4] = '{5'h1F, 5'h00, 5'h0A, 5'h15};
      apb(1'b1, 8'h2C, 32'h0000_0000);
      for (int m = 0; m < 4; m++) begin
         apb(1'b1, 8'h04, 32'h0);
         apb(1'b1, 8'h04, {1'b1, 2'(m), fifo[m], 24'h0});
         set_masks(m);
         send(32'hFFE0_0000, 1'b1, fifo[m]);
         set_masks((m + 1) % 4);
         send(32'hFFE0_0000, 1'b0, 5'h0);
      end
      apb(1'b1, 8'h04, 32'h0);
      apb(1'b1, 8'h04, 32'h8000_0000);
      mk <= '{32'h0, 32'h0, 32'h0, 32'h0};
      send(CAF_EXT_BIT, 1'b0, 5'h0);
      send(32'h0000_0000, 1'b1, 5'h00);
      apb(1'b1, 8'h04, 32'h0);
      send(32'h0000_0000, 1'b0, 5'h0);
   endtask

   task automatic t_unmapped();
      apb(1'b0, 8'h80, 32'h0);
      chk(e, 1'b1);
      chk(q, 32'h0);
   endtask

   // Extended-format filter 27, identifier lock while enabled, and the status word.
   task automatic t_ident();
      apb(1'b0, CAF_STATUS_OFS, 32'h0);
      chk(q, 32'h0001_1B00);
      chk(e, 1'b0);
      apb(1'b1, 8'h2C, 32'h0009_2345);
      apb(1'b0, 8'h2C, 32'h0);
      chk(q, 32'h0009_2345);
      mk <= '{32'h0, 32'hFFFF_FFFF, 32'h0, 32'h0};
      apb(1'b1, 8'h04, 32'hA700_0000);
      send(32'h0009_2345, 1'b1, 5'h07);
      send(32'h0009_2344, 1'b0, 5'h00);
      apb(1'b1, 8'h2C, 32'h0000_0000);
      apb(1'b0, 8'h2C, 32'h0);
      chk(q, 32'h0009_2345);
      apb(1'b0, CAF_STATUS_OFS, 32'h0);
      chk(q, 32'h0001_1B07);
      apb(1'b1, 8'h04, 32'h0000_0000);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #200000;
      fail_count++;
      stop_test();
   end

   initial begin
      repeat (5) @(posedge mclk);
      reset_n <= 1'b1;
      t_reset();
      t_layout();
      t_route();
      t_ident();
      t_unmapped();
      stop_test();
   end
endmodule
`default_nettype wire
